// >>> hdl/gscd_command_decoder.sv
`timescale 1ns/10ps
module gscd_command_decoder
    import gscd_pkg::*;
#(
    parameter longint DEGAS_CYCLES = DEGAS_CYC
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       rxValid,
    input  wire logic [7:0] rxByte,
    input  wire logic       frameAbort,
    output logic [1:0]      pressureUnit,
    output logic            degasOn,
    output logic            emissionAuto,
    output logic            emissionOn,
    output logic            filamentManualControl,
    output logic            filamentSel,
    output logic            storeUnit,
    output logic            storeEmissionMode,
    output logic            storeFilamentMode,
    output logic            storeFilamentSel,
    output logic            readFilamentStatus,
    output logic            readSoftwareVersion,
    output logic            resetRequest,
    output logic            frameRejected
);
    typedef struct packed {
        logic [1:0]         unit;
        logic               degas;
        logic [DEGAS_W-1:0] degasCnt;
        logic               emiAuto;
        logic               emiOn;
        logic               filManual;
        logic               filSel;
        logic               filPending;
        logic               filPendVal;
        logic               stUnit;
        logic               stEmi;
        logic               stFilMode;
        logic               stFilSel;
        logic               rdFil;
        logic               rdVer;
        logic               rst;
        logic               rej;
    } gscd_dec_t;

    gscd_dec_t state_reg;
    gscd_dec_t state_next;
    gscd_frame_if frm ();

    localparam logic [DEGAS_W-1:0] DEGAS_LAST = DEGAS_W'(DEGAS_CYCLES - 1);

    // checksum check keeps only the low byte of the sum
    function automatic logic sum_ok(input logic [7:0] a, input logic [7:0] b,
                                    input logic [7:0] c, input logic [7:0] s);
        logic [7:0] t;
        t = a + b + c;
        return t == s;
    endfunction : sum_ok

    // one-bit argument: only 0 or 1 are legal
    function automatic logic is_bit(input logic [7:0] v);
        return (v == ARG_ON) || (v == ARG_OFF);
    endfunction : is_bit

    gscd_frame_collect u_collect (
        .clk        (clk),
        .srst       (srst),
        .rxValid    (rxValid),
        .rxByte     (rxByte),
        .frameAbort (frameAbort),
        .frm        (frm.src)
    );

    logic good;
    assign good = frm.valid && (frm.lenByte == LEN_VALUE)
                  && sum_ok(frm.d1, frm.d2, frm.d3, frm.sumByte);

    // command decode; pulses last one cycle, settings hold until changed
    always_comb begin
        logic hit;
        hit                  = 1'b0;
        state_next           = state_reg;
        state_next.stUnit    = 1'b0;
        state_next.stEmi     = 1'b0;
        state_next.stFilMode = 1'b0;
        state_next.stFilSel  = 1'b0;
        state_next.rdFil     = 1'b0;
        state_next.rdVer     = 1'b0;
        state_next.rst       = 1'b0;
        state_next.rej       = 1'b0;
        // degas times out on its own
        if (state_reg.degas) begin
            if (state_reg.degasCnt >= DEGAS_LAST) begin
                state_next.degas    = 1'b0;
                state_next.degasCnt = '0;
            end else begin
                state_next.degasCnt = state_reg.degasCnt + DEGAS_ONE;
            end
        end
        // deferred filament selection waits for emission off
        if (state_reg.filPending && !state_reg.emiOn) begin
            state_next.filSel     = state_reg.filPendVal;
            state_next.filPending = 1'b0;
        end
        if (good) begin
            unique case (frm.d1)
                GRP_SET: begin
                    if (frm.d2 == SEL_UNIT && frm.d3 <= ARG_MAX_UNIT) begin
                        hit = 1'b1;
                        state_next.unit = frm.d3[1:0];
                    end else if (frm.d2 == SEL_DEGAS && is_bit(frm.d3)) begin
                        hit = 1'b1;
                        state_next.degas    = frm.d3[0];
                        state_next.degasCnt = '0;
                    end else if (frm.d2 == SEL_EMIMODE && is_bit(frm.d3)) begin
                        hit = 1'b1;
                        state_next.emiAuto = frm.d3[0];
                    end else if (frm.d2 == SEL_FILMODE && is_bit(frm.d3)) begin
                        hit = 1'b1;
                        state_next.filManual = frm.d3[0];
                    end else if (frm.d2 == SEL_FILSEL && is_bit(frm.d3)) begin
                        hit = 1'b1;
                        state_next.filPending = 1'b1;
                        state_next.filPendVal = frm.d3[0];
                    end
                end
                GRP_STORE: begin
                    hit = 1'b1;
                    if (frm.d2 == STO_UNIT) begin
                        state_next.stUnit = 1'b1;
                    end else if (frm.d2 == STO_EMIMODE) begin
                        state_next.stEmi = 1'b1;
                    end else if (frm.d2 == STO_FILMODE) begin
                        state_next.stFilMode = 1'b1;
                    end else if (frm.d2 == STO_FILSEL) begin
                        state_next.stFilSel = 1'b1;
                    end else begin
                        hit = 1'b0;
                    end
                end
                GRP_ACT: begin
                    if (frm.d2 == SEL_EMISSION && is_bit(frm.d3)) begin
                        hit = 1'b1;
                        // ignored while the gauge owns emission
                        if (!state_reg.emiAuto) begin
                            state_next.emiOn = frm.d3[0];
                        end
                    end else if (frm.d2 == SEL_RESET && frm.d3 == ARG_OFF) begin
                        hit = 1'b1;
                        state_next.rst = 1'b1;
                    end
                end
                GRP_READ: begin
                    if (frm.d2 == SEL_RDFIL) begin
                        hit = 1'b1;
                        state_next.rdFil = 1'b1;
                    end else if (frm.d2 == SEL_RDVER) begin
                        hit = 1'b1;
                        state_next.rdVer = 1'b1;
                    end
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
        end
        // bad frame: nothing above was touched by it
        if (frm.valid && !hit) begin
            state_next.rej = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg          <= '0;
            state_reg.unit     <= UNIT_MBAR;
            state_reg.emiAuto  <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pressureUnit          = state_reg.unit;
    assign degasOn               = state_reg.degas;
    assign emissionAuto          = state_reg.emiAuto;
    assign emissionOn            = state_reg.emiOn;
    assign filamentManualControl = state_reg.filManual;
    assign filamentSel           = state_reg.filSel;
    assign storeUnit             = state_reg.stUnit;
    assign storeEmissionMode     = state_reg.stEmi;
    assign storeFilamentMode     = state_reg.stFilMode;
    assign storeFilamentSel      = state_reg.stFilSel;
    assign readFilamentStatus    = state_reg.rdFil;
    assign readSoftwareVersion   = state_reg.rdVer;
    assign resetRequest          = state_reg.rst;
    assign frameRejected         = state_reg.rej;

    sequence s_good_unit;
        good && frm.d1 == GRP_SET && frm.d2 == SEL_UNIT && frm.d3 <= ARG_MAX_UNIT;
    endsequence

    a_unit_set: assert property (@(posedge clk) disable iff (srst)
        s_good_unit |=> pressureUnit == $past(frm.d3[1:0]))
        else $error("unit not applied");
    a_unit_store: assert property (@(posedge clk) disable iff (srst)
        good && frm.d1 == GRP_STORE && frm.d2 == STO_UNIT |=> storeUnit ##1 !storeUnit)
        else $error("unit store pulse wrong");
    a_degas_limit: assert property (@(posedge clk) disable iff (srst)
        degasOn |-> state_reg.degasCnt <= DEGAS_LAST)
        else $error("degas ran past limit");
    a_degas_stop: assert property (@(posedge clk) disable iff (srst)
        good && frm.d1 == GRP_SET && frm.d2 == SEL_DEGAS && frm.d3 == ARG_OFF |=> !degasOn)
        else $error("degas not stopped");
    a_emi_mode: assert property (@(posedge clk) disable iff (srst)
        good && frm.d1 == GRP_SET && frm.d2 == SEL_EMIMODE && is_bit(frm.d3)
        |=> emissionAuto == $past(frm.d3[0]))
        else $error("emission mode wrong");
    a_emi_store: assert property (@(posedge clk) disable iff (srst)
        good && frm.d1 == GRP_STORE && frm.d2 == STO_EMIMODE |=> storeEmissionMode)
        else $error("emission mode store missing");
    a_emi_auto_hold: assert property (@(posedge clk) disable iff (srst)
        emissionAuto && $stable(emissionAuto) |=> $stable(emissionOn))
        else $error("emission changed in auto mode");
    a_fil_mode: assert property (@(posedge clk) disable iff (srst)
        good && frm.d1 == GRP_SET && frm.d2 == SEL_FILMODE && is_bit(frm.d3)
        |=> filamentManualControl == $past(frm.d3[0]))
        else $error("filament mode wrong");
    a_fil_store: assert property (@(posedge clk) disable iff (srst)
        good && frm.d1 == GRP_STORE && frm.d2 == STO_FILMODE |=> storeFilamentMode)
        else $error("filament mode store missing");
    a_fil_emi_off: assert property (@(posedge clk) disable iff (srst)
        $changed(filamentSel) |-> $past(!emissionOn))
        else $error("filament changed with emission on");
    a_fil_sel_store: assert property (@(posedge clk) disable iff (srst)
        good && frm.d1 == GRP_STORE && frm.d2 == STO_FILSEL |=> storeFilamentSel)
        else $error("filament store missing");
    a_reset_req: assert property (@(posedge clk) disable iff (srst)
        resetRequest |-> $past(good && frm.d1 == GRP_ACT && frm.d2 == SEL_RESET))
        else $error("spurious reset request");
    a_bad_sum: assert property (@(posedge clk) disable iff (srst)
        frm.valid && !sum_ok(frm.d1, frm.d2, frm.d3, frm.sumByte)
        |=> frameRejected && $stable(pressureUnit) && $stable(emissionAuto))
        else $error("bad checksum accepted");
endmodule : gscd_command_decoder

// >>> hdl/gscd_pkg.sv
package gscd_pkg;
    // frame layout
    localparam int          FRAME_BYTES   = 5;
    localparam logic [7:0]  LEN_VALUE     = 8'h03;
    // first data byte groups
    localparam logic [7:0]  GRP_READ      = 8'h00;
    localparam logic [7:0]  GRP_SET       = 8'h10;
    localparam logic [7:0]  GRP_STORE     = 8'h20;
    localparam logic [7:0]  GRP_ACT       = 8'h40;
    // second data byte selectors
    localparam logic [7:0]  SEL_UNIT      = 8'h8e;
    localparam logic [7:0]  SEL_DEGAS     = 8'hc4;
    localparam logic [7:0]  SEL_EMIMODE   = 8'h8a;
    localparam logic [7:0]  SEL_FILMODE   = 8'hd3;
    localparam logic [7:0]  SEL_FILSEL    = 8'hd2;
    localparam logic [7:0]  SEL_EMISSION  = 8'h10;
    localparam logic [7:0]  SEL_RESET     = 8'h00;
    localparam logic [7:0]  SEL_RDFIL     = 8'hd4;
    localparam logic [7:0]  SEL_RDVER     = 8'hd1;
    localparam logic [7:0]  STO_UNIT      = 8'h02;
    localparam logic [7:0]  STO_EMIMODE   = 8'h01;
    localparam logic [7:0]  STO_FILMODE   = 8'h0d;
    localparam logic [7:0]  STO_FILSEL    = 8'h0c;
    // unit codes and argument values
    localparam logic [1:0]  UNIT_MBAR     = 2'h0;
    localparam logic [1:0]  UNIT_PA       = 2'h2;
    localparam logic [7:0]  ARG_ON        = 8'h01;
    localparam logic [7:0]  ARG_OFF       = 8'h00;
    localparam logic [7:0]  ARG_MAX_UNIT  = 8'h02;
    // degas duration, then frame byte indices
    localparam longint      CLK_HZ        = 125000000;
    localparam longint      DEGAS_S       = 180;
    localparam longint      DEGAS_CYC     = DEGAS_S * CLK_HZ;
    localparam int          DEGAS_W       = 35;
    localparam logic [DEGAS_W-1:0] DEGAS_ONE = 35'h1;
    localparam logic [2:0]  IDX_ZERO      = 3'h0;
    localparam logic [2:0]  IDX_ONE       = 3'h1;
    localparam logic [2:0]  IDX_LAST      = 3'h4;
endpackage : gscd_pkg

// >>> hdl/gscd_frame_if.sv
`timescale 1ns/10ps
// assembled frame handed from the byte collector to the decoder
interface gscd_frame_if;
    logic       valid;
    logic [7:0] lenByte;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] d3;
    logic [7:0] sumByte;
    modport src (output valid, output lenByte, output d1, output d2, output d3, output sumByte);
    modport dst (input valid, input lenByte, input d1, input d2, input d3, input sumByte);
endinterface : gscd_frame_if

// >>> hdl/gscd_frame_collect.sv
`timescale 1ns/10ps
module gscd_frame_collect
    import gscd_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   srst,
    input  wire logic   rxValid,
    input  wire logic [7:0] rxByte,
    input  wire logic   frameAbort,
    gscd_frame_if.src   frm
);
    typedef struct packed {
        logic [2:0]  idx;
        logic [39:0] bytes;
        logic        valid;
    } gscd_col_t;

    gscd_col_t state_reg;
    gscd_col_t state_next;

    // shift bytes in, flag a full frame of five for one cycle
    always_comb begin
        state_next       = state_reg;
        state_next.valid = 1'b0;
        if (frameAbort) begin
            state_next.idx = IDX_ZERO;
        end else if (rxValid) begin
            state_next.bytes = {state_reg.bytes[31:0], rxByte};
            if (state_reg.idx == IDX_LAST) begin
                state_next.idx   = IDX_ZERO;
                state_next.valid = 1'b1;
            end else begin
                state_next.idx = state_reg.idx + IDX_ONE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign frm.valid   = state_reg.valid;
    assign frm.lenByte = state_reg.bytes[39:32];
    assign frm.d1      = state_reg.bytes[31:24];
    assign frm.d2      = state_reg.bytes[23:16];
    assign frm.d3      = state_reg.bytes[15:8];
    assign frm.sumByte = state_reg.bytes[7:0];

    a_frame_count: assert property (@(posedge clk) disable iff (srst)
        state_reg.valid |-> $past(rxValid) && $past(state_reg.idx) == IDX_LAST)
        else $error("frame flagged without fifth byte");
endmodule : gscd_frame_collect

// >>> verification/gscd_host_model.sv
`timescale 1ns/10ps
// host side of the serial link; every call starts just after a rising edge
module gscd_host_model (
    input  wire logic       clk,
    output logic            rxValid,
    output logic [7:0]      rxByte,
    output logic            frameAbort
);
    initial begin
        rxValid    = 1'b0;
        rxByte     = 8'h5a;
        frameAbort = 1'b0;
    end

    // whole frame, one byte a cycle, no trailing terminator
    task send_frame(input logic [7:0] lenB, input logic [7:0] d1, input logic [7:0] d2,
                    input logic [7:0] d3, input logic [7:0] sumB, input logic keep);
        logic [7:0] b [5];
        b = '{lenB, d1, d2, d3, sumB};
        for (int i = 0; i < 5; i++) begin
            rxValid = 1'b1;
            rxByte  = b[i];
            @(posedge clk);
            #1;
        end
        // idle shows the inverse so a stale byte never looks like data
        if (!keep) begin
            rxValid = 1'b0;
            rxByte  = ~rxByte;
        end
    endtask : send_frame

    // two bytes of a frame, then a frameAbort pulse that drops them
    task abort_partial(input logic [7:0] lenB, input logic [7:0] d1);
        rxValid = 1'b1;
        rxByte  = lenB;
        @(posedge clk);
        #1;
        rxByte = d1;
        @(posedge clk);
        #1;
        rxValid    = 1'b0;
        rxByte     = ~d1;
        frameAbort = 1'b1;
        @(posedge clk);
        #1;
        frameAbort = 1'b0;
    endtask : abort_partial
endmodule : gscd_host_model

// >>> verification/test_gscd_command_decoder.sv
`timescale 1ns/10ps
module test_gscd_command_decoder;
    localparam longint SIM_DEGAS   = 20;
    localparam int     TIMEOUT_CYC = 3000;

    logic       clk;
    logic       srst;
    logic       rxValid;
    logic [7:0] rxByte;
    logic       frameAbort;
    logic [1:0] pressureUnit;
    logic       degasOn, emissionAuto, emissionOn, filamentManualControl, filamentSel;
    logic       storeUnit, storeEmissionMode, storeFilamentMode, storeFilamentSel;
    logic       readFilamentStatus, readSoftwareVersion, resetRequest, frameRejected;
    logic [6:0] setNow;
    logic [7:0] pulseNow;
    logic [6:0] expSet;
    int         failures;
    int         check_count;
    int         cycles;
    int         waitN;

    gscd_command_decoder #(.DEGAS_CYCLES(SIM_DEGAS)) i_gscd_command_decoder (
        .clk(clk), .srst(srst), .rxValid(rxValid), .rxByte(rxByte), .frameAbort(frameAbort),
        .pressureUnit(pressureUnit), .degasOn(degasOn), .emissionAuto(emissionAuto),
        .emissionOn(emissionOn), .filamentManualControl(filamentManualControl),
        .filamentSel(filamentSel), .storeUnit(storeUnit),
        .storeEmissionMode(storeEmissionMode), .storeFilamentMode(storeFilamentMode),
        .storeFilamentSel(storeFilamentSel), .readFilamentStatus(readFilamentStatus),
        .readSoftwareVersion(readSoftwareVersion), .resetRequest(resetRequest),
        .frameRejected(frameRejected));

    gscd_host_model i_gscd_host_model (
        .clk(clk), .rxValid(rxValid), .rxByte(rxByte), .frameAbort(frameAbort));

    // settings as {unit, degas, auto, emission, manual filament, filament}
    assign setNow   = {pressureUnit, degasOn, emissionAuto, emissionOn,
                       filamentManualControl, filamentSel};
    assign pulseNow = {storeUnit, storeEmissionMode, storeFilamentMode, storeFilamentSel,
                       readFilamentStatus, readSoftwareVersion, resetRequest, frameRejected};

    always #4 clk = ~clk;

    // hang guard, well beyond the length of the sequence
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYC) begin
            failures = failures + 1;
            end_of_test();
        end
    end

    task check_set(input string what, input logic [6:0] exp, input logic [6:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check_set

    task check_pulse(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check_pulse

    task check_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    // one frame; pulses stand for the one cycle after the edge that follows the checksum byte,
    // settings are looked at two edges later so a deferred filament choice has landed
    task frame(input string what, input logic [7:0] lenB, input logic [7:0] d1,
               input logic [7:0] d2, input logic [7:0] d3, input logic [7:0] sumAdj,
               input logic [7:0] expPulse);
        logic [7:0] sumB;
        sumB = d1 + d2 + d3 + sumAdj;  // eight-bit sum, carry dropped
        i_gscd_host_model.send_frame(lenB, d1, d2, d3, sumB, 1'b0);
        @(posedge clk);
        #1;
        check_pulse({what, " pulse"}, expPulse, pulseNow);
        @(posedge clk);
        #1;
        check_pulse({what, " pulse end"}, 8'h00, pulseNow);
        @(posedge clk);
        #1;
        check_set({what, " settings"}, expSet, setNow);
        $display("test %s done", what);
    endtask : frame

    task end_of_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    // store, read and reset commands with the pulse each must give
    logic [7:0] tD1 [7] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h00, 8'h00, 8'h40};
    logic [7:0] tD2 [7] = '{8'h02, 8'h01, 8'h0d, 8'h0c, 8'hd4, 8'hd1, 8'h00};
    logic [7:0] tD3 [7] = '{8'hf0, 8'h00, 8'h07, 8'hff, 8'h00, 8'h00, 8'h00};
    logic [7:0] tP  [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02};
    // refused frames: bad length, bad checksum, unknown selector, unit out of range
    logic [7:0] rLen [4] = '{8'h04, 8'h03, 8'h03, 8'h03};
    logic [7:0] rD2  [4] = '{8'h8e, 8'h8e, 8'h63, 8'h8e};
    logic [7:0] rD3  [4] = '{8'h01, 8'h01, 8'h00, 8'h03};
    logic [7:0] rAdj [4] = '{8'h00, 8'h01, 8'h00, 8'h00};

    initial begin
        clk         = 1'b0;
        srst        = 1'b1;
        failures    = 0;
        check_count = 0;
        cycles      = 0;
        waitN       = 0;
        expSet      = 7'b00_0_1_0_0_0;
        repeat (12) @(posedge clk);
        #1;
        srst = 1'b0;
        check_set("reset settings", expSet, setNow);
        check_pulse("reset pulses", 8'h00, pulseNow);
        for (int i = 1; i <= 3; i++) begin
            expSet[6:5] = 2'(i % 3);
            frame("unit", 8'h03, 8'h10, 8'h8e, 8'(i % 3), 8'h00, 8'h00);
        end
        for (int i = 0; i < 4; i++)
            frame("store", 8'h03, tD1[i], tD2[i], tD3[i], 8'h00, tP[i]);
        for (int i = 4; i < 7; i++)
            frame("read reset", 8'h03, tD1[i], tD2[i], tD3[i], 8'h00, tP[i]);
        for (int i = 0; i < 4; i++)
            frame("refused", rLen[i], 8'h10, rD2[i], rD3[i], rAdj[i], 8'h01);
        frame("emission in auto", 8'h03, 8'h40, 8'h10, 8'h01, 8'h00, 8'h00);
        expSet[3] = 1'b0;
        frame("manual emission", 8'h03, 8'h10, 8'h8a, 8'h00, 8'h00, 8'h00);
        expSet[2] = 1'b1;
        frame("emission on", 8'h03, 8'h40, 8'h10, 8'h01, 8'h00, 8'h00);
        expSet[1] = 1'b1;
        frame("manual filament", 8'h03, 8'h10, 8'hd3, 8'h01, 8'h00, 8'h00);
        frame("filament held", 8'h03, 8'h10, 8'hd2, 8'h01, 8'h00, 8'h00);
        expSet[2] = 1'b0;
        expSet[0] = 1'b1;
        frame("emission off", 8'h03, 8'h40, 8'h10, 8'h00, 8'h00, 8'h00);
        expSet[0] = 1'b0;
        frame("filament one", 8'h03, 8'h10, 8'hd2, 8'h00, 8'h00, 8'h00);
        expSet[3] = 1'b1;
        frame("auto emission", 8'h03, 8'h10, 8'h8a, 8'h01, 8'h00, 8'h00);
        expSet[1] = 1'b0;
        frame("auto filament", 8'h03, 8'h10, 8'hd3, 8'h00, 8'h00, 8'h00);
        expSet[4] = 1'b1;
        frame("degas on", 8'h03, 8'h10, 8'hc4, 8'h01, 8'h00, 8'h00);
        expSet[4] = 1'b0;
        frame("degas stop", 8'h03, 8'h10, 8'hc4, 8'h00, 8'h00, 8'h00);
        expSet[4] = 1'b1;
        frame("degas timed", 8'h03, 8'h10, 8'hc4, 8'h01, 8'h00, 8'h00);
        while (degasOn === 1'b1 && waitN < SIM_DEGAS + 10) begin
            @(posedge clk);
            #1;
            waitN++;
        end
        // two cycles of degas had already run when the frame task returned
        check_bit("degas length", 1'b1, waitN + 2 == SIM_DEGAS);
        expSet[4] = 1'b0;
        check_set("degas ended", expSet, setNow);
        i_gscd_host_model.abort_partial(8'h03, 8'h10);
        expSet[6:5] = 2'h2;
        frame("after abort", 8'h03, 8'h10, 8'h8e, 8'h02, 8'h00, 8'h00);
        i_gscd_host_model.send_frame(8'h03, 8'h10, 8'h8e, 8'h00, 8'h9e, 1'b1);
        expSet[6:5] = 2'h1;
        frame("back to back", 8'h03, 8'h10, 8'h8e, 8'h01, 8'h00, 8'h00);
        end_of_test();
    end
endmodule : test_gscd_command_decoder
